// [verilog/tmr8_pkg.sv]
// package: register map, field layout, reset values and clock-select codes of the 8-bit timer
`default_nettype none
package tmr8_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_FLAGS = 6'h15;
  localparam logic [5:0] IDX_CTRL  = 6'h24;
  localparam logic [5:0] IDX_COUNT = 6'h26;
  localparam logic [5:0] IDX_CMP_A = 6'h27;
  localparam logic [5:0] IDX_CMP_B = 6'h28;
  localparam logic [5:0] IDX_MASK  = 6'h2E;

  // writable bits of each register
  localparam logic [7:0] CTRL_WMASK = 8'h0F;
  localparam logic [7:0] IRQ_WMASK  = 8'h07;

  // reset values
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP_A = 8'h00;
  localparam logic [7:0] RST_CMP_B = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // count range
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // interrupt source positions in mask, flags, request and acknowledge vectors
  localparam int SRC_WRAP    = 0;
  localparam int SRC_MATCH_A = 1;
  localparam int SRC_MATCH_B = 2;
  localparam int SRC_N       = 3;

  // prescaler width and divide ratios
  localparam int         PRE_W    = 10;
  localparam logic [9:0] DIV_8    = 10'h008;
  localparam logic [9:0] DIV_64   = 10'h040;
  localparam logic [9:0] DIV_256  = 10'h100;
  localparam logic [9:0] DIV_1024 = 10'h400;

  typedef enum logic [2:0] {
    CS_STOP     = 3'h0,
    CS_DIV1     = 3'h1,
    CS_DIV8     = 3'h2,
    CS_DIV64    = 3'h3,
    CS_DIV256   = 3'h4,
    CS_DIV1024  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } tmr8_clk_src_e;

  typedef struct packed {
    logic [3:0]    rsvd;
    logic          clear_on_match_sel;
    tmr8_clk_src_e clk_src_sel;
  } tmr8_ctrl_s;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       match_b;
    logic       match_a;
    logic       wrap;
  } tmr8_irq_s;

endpackage
`default_nettype wire

// [verilog/tmr8_tick_gen.sv]
// module: prescaler and clock-select logic producing the one-cycle timer tick
`default_nettype none
module tmr8_tick_gen (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // selection and external pin
  input  wire tmr8_pkg::tmr8_clk_src_e clk_src_sel_i,
  input  wire logic                   ext_count_pin_i,
  // tick
  output logic                        timer_tick_o
);

  logic [tmr8_pkg::PRE_W-1:0] pre;
  logic                       pin_meta;
  logic                       pin_sync;
  logic                       pin_last;
  logic                       ext_rise;
  logic                       ext_fall;

  // true on the last io_clock cycle of each period of the given ratio
  function automatic logic tap(input logic [9:0] p, input logic [9:0] div);
    tap = ((p & (div - 10'h001)) == (div - 10'h001));
  endfunction

  // free-running prescaler shared by all divided sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre <= '0;
    end else begin
      pre <= pre + 10'h001;
    end
  end

  // pin is sampled regardless of its port direction, so software can toggle it [R06]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= ext_count_pin_i;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign ext_rise = pin_sync & ~pin_last; // [R20]
  assign ext_fall = ~pin_sync & pin_last; // [R20]

  // clock select decode [R04] [R05]
  assign timer_tick_o =
    (clk_src_sel_i == tmr8_pkg::CS_DIV1)     ? 1'b1 :
    (clk_src_sel_i == tmr8_pkg::CS_DIV8)     ? tap(pre, tmr8_pkg::DIV_8) :
    (clk_src_sel_i == tmr8_pkg::CS_DIV64)    ? tap(pre, tmr8_pkg::DIV_64) :
    (clk_src_sel_i == tmr8_pkg::CS_DIV256)   ? tap(pre, tmr8_pkg::DIV_256) :
    (clk_src_sel_i == tmr8_pkg::CS_DIV1024)  ? tap(pre, tmr8_pkg::DIV_1024) :
    (clk_src_sel_i == tmr8_pkg::CS_EXT_FALL) ? ext_fall :
    (clk_src_sel_i == tmr8_pkg::CS_EXT_RISE) ? ext_rise : 1'b0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_stop_no_tick;
    clk_src_sel_i == tmr8_pkg::CS_STOP |-> !timer_tick_o;
  endproperty
  a_stop_no_tick : assert property (p_stop_no_tick) // [R04]
    else $error("tick while clock source stopped");

  property p_div8_spacing;
    clk_src_sel_i == tmr8_pkg::CS_DIV8 && timer_tick_o
      ##1 clk_src_sel_i == tmr8_pkg::CS_DIV8 [*7] |-> !$past(timer_tick_o);
  endproperty
  a_div8_spacing : assert property (p_div8_spacing) // [R04]
    else $error("divide-by-8 tick came early");

  property p_ext_fall_tick;
    clk_src_sel_i == tmr8_pkg::CS_EXT_FALL ##0 $fell(ext_count_pin_i)
      ##2 clk_src_sel_i == tmr8_pkg::CS_EXT_FALL [*2] |-> $past(timer_tick_o) || timer_tick_o;
  endproperty
  a_ext_fall_tick : assert property (p_ext_fall_tick) // [R05]
    else $error("falling pin edge not counted");

  property p_ext_rise_only;
    clk_src_sel_i == tmr8_pkg::CS_EXT_RISE && timer_tick_o |-> $rose(pin_sync);
  endproperty
  a_ext_rise_only : assert property (p_ext_rise_only) // [R05]
    else $error("rising mode ticked without rising edge");

endmodule
`default_nettype wire

// [verilog/tmr8_timer.sv]
// module: 8-bit timer/counter with two compare channels, wishbone register slave
//
// Operation
// [R01] control upper nibble reads zero, ignores writes
// [R02] mode bit picks free-run or clear-on-match
// [R03] overflow flag set when counter passes 0xFF
// [R04] clock select: stop, undivided, /8 /64 /256 /1024
// [R05] select 110 counts pin falls, 111 rises
// [R06] pin counted even when configured as output
// [R07] counter readable and writable any time
// [R08] counter write blocks matches on next tick
// [R09] software should not rewrite a running counter
// [R10] compare A matched continuously, resets to zero
// [R11] compare B matched continuously
// [R12] request needs mask, flag and global enable
// [R13] match B flag: set on match, cleared
// [R14] match A flag: set on match, cleared
// [R15] wrap flag: set on overflow, cleared
// [R16] compare flag set on tick after equality
// [R17] clear-on-match zeroes counter tick after match
// [R18] counter write beats count and clear
// [R19] wrap flag set as counter wraps
// [R20] pin synchronised, edge gives one-cycle tick
// [R21] acknowledge input clears its flag
//
// Local design decision: the Wishbone register port.
`default_nettype none
module tmr8_timer (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // external count pin
  input  wire logic                        ext_count_pin_i,
  // cpu interrupt side
  input  wire logic                        gie_i,
  input  wire logic [tmr8_pkg::SRC_N-1:0]  irq_ack_i,
  output logic      [tmr8_pkg::SRC_N-1:0]  irq_o
);

  tmr8_pkg::tmr8_ctrl_s ctrl;
  tmr8_pkg::tmr8_irq_s  mask;
  tmr8_pkg::tmr8_irq_s  flags;
  logic [7:0]           count;
  logic [7:0]           cmp_a;
  logic [7:0]           cmp_b;
  logic                 block;

  tmr8_pkg::tmr8_ctrl_s next_ctrl;
  tmr8_pkg::tmr8_irq_s  next_mask;
  logic [7:0]           next_count;
  logic [7:0]           next_cmp_a;
  logic [7:0]           next_cmp_b;
  logic [2:0]           next_flags;
  logic                 next_block;
  logic [31:0]          next_dat;

  // ---------------- bus slave ----------------

  logic       wb_req;
  logic       wb_take;
  logic       wr_en;
  logic [5:0] idx;
  logic       hit_ctrl;
  logic       hit_count;
  logic       hit_cmp_a;
  logic       hit_cmp_b;
  logic       hit_mask;
  logic       hit_flags;
  logic       wr_ctrl;
  logic       wr_count;
  logic       wr_cmp_a;
  logic       wr_cmp_b;
  logic       wr_mask;
  logic       wr_flags;
  logic [7:0] rd_data;
  logic [7:0] wdat;

  assign wb_req  = wb_cyc_i & wb_stb_i;
  // the access is answered one cycle after the request and retired at the ack edge
  assign wb_take = wb_req & ~wb_ack_o;
  assign wr_en   = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[7:2];
  assign wdat    = wb_dat_i[7:0];

  assign hit_ctrl  = (idx == tmr8_pkg::IDX_CTRL);
  assign hit_count = (idx == tmr8_pkg::IDX_COUNT);
  assign hit_cmp_a = (idx == tmr8_pkg::IDX_CMP_A);
  assign hit_cmp_b = (idx == tmr8_pkg::IDX_CMP_B);
  assign hit_mask  = (idx == tmr8_pkg::IDX_MASK);
  assign hit_flags = (idx == tmr8_pkg::IDX_FLAGS);

  assign wr_ctrl  = wr_en & hit_ctrl;
  assign wr_count = wr_en & hit_count;
  assign wr_cmp_a = wr_en & hit_cmp_a;
  assign wr_cmp_b = wr_en & hit_cmp_b;
  assign wr_mask  = wr_en & hit_mask;
  assign wr_flags = wr_en & hit_flags;

  // unmapped indices read as zero and writes to them are dropped
  assign rd_data =
    hit_ctrl  ? ctrl :  // [R01]
    hit_count ? count : // [R07]
    hit_cmp_a ? cmp_a :
    hit_cmp_b ? cmp_b :
    hit_mask  ? mask :
    hit_flags ? flags : 8'h00;

  assign next_dat = wb_take ? {24'h00_0000, rd_data} : wb_dat_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_take;
      wb_dat_o <= next_dat;
    end
  end

  // ---------------- configuration registers ----------------

  // reserved control bits are masked on the way in so they always read zero
  assign next_ctrl = wr_ctrl ? tmr8_pkg::tmr8_ctrl_s'(wdat & tmr8_pkg::CTRL_WMASK) : ctrl; // [R01]
  assign next_mask = wr_mask ? tmr8_pkg::tmr8_irq_s'(wdat & tmr8_pkg::IRQ_WMASK) : mask;
  // no double buffering: a new compare value acts on the very next comparison [R02]
  assign next_cmp_a = wr_cmp_a ? wdat : cmp_a; // [R10]
  assign next_cmp_b = wr_cmp_b ? wdat : cmp_b; // [R11]

  // ---------------- timer tick ----------------

  logic timer_tick;

  tmr8_tick_gen u_tick (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .clk_src_sel_i   (ctrl.clk_src_sel),
    .ext_count_pin_i (ext_count_pin_i),
    .timer_tick_o    (timer_tick)
  );

  // ---------------- counter and compare ----------------

  logic       match_a;
  logic       match_b;
  logic       ctc_clear;
  logic       at_max;
  logic       wrap_evt;
  logic       set_a;
  logic       set_b;
  logic [2:0] set_vec;
  logic [2:0] clr_vec;

  assign match_a   = (count == cmp_a); // [R10]
  assign match_b   = (count == cmp_b); // [R11]
  assign at_max    = (count == tmr8_pkg::COUNT_MAX);
  assign ctc_clear = ctrl.clear_on_match_sel & match_a; // [R02] [R17]

  // a bus write overrides any count or clear in the same cycle [R18] [R07]
  assign next_count =
    wr_count   ? wdat :
    !timer_tick ? count :
    ctc_clear  ? tmr8_pkg::COUNT_BOTTOM : count + 8'h01; // [R17]

  // overflow is taken as the tick on which the counter leaves 0xFF, in either mode;
  // in clear-on-match with compare A at 0xFF the clear also counts as a wrap
  assign wrap_evt = timer_tick & at_max & ~wr_count; // [R03] [R19]

  // a match seen on a tick is flagged at that tick's edge, one tick after equality began
  assign set_a = timer_tick & match_a & ~block; // [R16] [R08]
  assign set_b = timer_tick & match_b & ~block; // [R16] [R08]

  // one-tick blocking window armed by every counter write, running or stopped
  assign next_block = wr_count ? 1'b1 : (timer_tick ? 1'b0 : block); // [R08]

  // ---------------- flags and requests ----------------

  assign set_vec = {set_b, set_a, wrap_evt};
  // clear by writing one, or by the vector being taken [R21]
  assign clr_vec = (wr_flags ? wdat[2:0] : 3'h0) | irq_ack_i;
  // a set in the same cycle as a clear wins so no event is lost
  assign next_flags = ({flags.match_b, flags.match_a, flags.wrap} & ~clr_vec)
                    | set_vec; // [R13] [R14] [R15]

  assign irq_o = {flags.match_b, flags.match_a, flags.wrap}
               & {mask.match_b, mask.match_a, mask.wrap}
               & {tmr8_pkg::SRC_N{gie_i}}; // [R12]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl  <= tmr8_pkg::tmr8_ctrl_s'(tmr8_pkg::RST_CTRL);
      mask  <= tmr8_pkg::tmr8_irq_s'(tmr8_pkg::RST_MASK);
      flags <= tmr8_pkg::tmr8_irq_s'(tmr8_pkg::RST_FLAGS);
      count <= tmr8_pkg::RST_COUNT;
      cmp_a <= tmr8_pkg::RST_CMP_A; // [R10]
      cmp_b <= tmr8_pkg::RST_CMP_B;
      block <= 1'b0;
    end else begin
      ctrl  <= next_ctrl;
      mask  <= next_mask;
      flags <= tmr8_pkg::tmr8_irq_s'({5'h00, next_flags});
      count <= next_count;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      block <= next_block;
    end
  end

  // ---------------- checks ----------------

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ctrl_rsvd_zero;
    wb_take && hit_ctrl && !wb_we_i |=> wb_ack_o && wb_dat_o[7:4] == 4'h0;
  endproperty
  a_ctrl_rsvd_zero : assert property (p_ctrl_rsvd_zero) // [R01]
    else $error("control upper nibble not zero");

  property p_free_wrap;
    timer_tick && !ctrl.clear_on_match_sel && at_max && !wr_count
      |=> count == tmr8_pkg::COUNT_BOTTOM && flags.wrap;
  endproperty
  a_free_wrap : assert property (p_free_wrap) // [R03]
    else $error("free-running wrap missed or flag not set");

  property p_free_runs_past_a;
    timer_tick && !ctrl.clear_on_match_sel && match_a && !at_max && !wr_count
      |=> count == $past(count) + 8'h01;
  endproperty
  a_free_runs_past_a : assert property (p_free_runs_past_a) // [R02]
    else $error("free-running counter cleared on compare A");

  property p_ctc_clear;
    timer_tick && ctrl.clear_on_match_sel && match_a && !wr_count
      |=> count == tmr8_pkg::COUNT_BOTTOM;
  endproperty
  a_ctc_clear : assert property (p_ctc_clear) // [R17]
    else $error("clear-on-match did not zero counter");

  property p_write_wins;
    wr_count |=> count == $past(wdat);
  endproperty
  a_write_wins : assert property (p_write_wins) // [R18]
    else $error("counter write lost");

  property p_match_sets_a;
    timer_tick && match_a && !block |=> flags.match_a;
  endproperty
  a_match_sets_a : assert property (p_match_sets_a) // [R14]
    else $error("compare A flag not set");

  property p_match_sets_b;
    timer_tick && match_b && !block |=> flags.match_b;
  endproperty
  a_match_sets_b : assert property (p_match_sets_b) // [R13]
    else $error("compare B flag not set");

  // the window may last any number of cycles, so it is watched through the block flop
  property p_block_after_write;
    block && timer_tick && !wr_count && !flags.match_b |=> !flags.match_b;
  endproperty
  a_block_after_write : assert property (p_block_after_write) // [R08]
    else $error("match not blocked after counter write");

  property p_block_armed;
    wr_count |=> block;
  endproperty
  a_block_armed : assert property (p_block_armed) // [R08]
    else $error("counter write did not arm the match block");

  property p_block_drops;
    block && timer_tick && !wr_count |=> !block;
  endproperty
  a_block_drops : assert property (p_block_drops) // [R08]
    else $error("match block outlived its tick");

  property p_stop_holds;
    ctrl.clk_src_sel == tmr8_pkg::CS_STOP && !wr_count |=> count == $past(count);
  endproperty
  a_stop_holds : assert property (p_stop_holds) // [R04]
    else $error("stopped counter moved");

  property p_no_spurious_a;
    !flags.match_a && !(timer_tick && match_a) |=> !flags.match_a;
  endproperty
  a_no_spurious_a : assert property (p_no_spurious_a) // [R16]
    else $error("compare A flag set without tick match");

  property p_no_spurious_b;
    !flags.match_b && !(timer_tick && match_b) |=> !flags.match_b;
  endproperty
  a_no_spurious_b : assert property (p_no_spurious_b) // [R16]
    else $error("compare B flag set without tick match");

  property p_w1c_match_a;
    wr_flags && wdat[tmr8_pkg::SRC_MATCH_A] && !set_a |=> !flags.match_a;
  endproperty
  a_w1c_match_a : assert property (p_w1c_match_a) // [R14]
    else $error("compare A flag not cleared by write one");

  property p_w1c_match_b;
    wr_flags && wdat[tmr8_pkg::SRC_MATCH_B] && !set_b |=> !flags.match_b;
  endproperty
  a_w1c_match_b : assert property (p_w1c_match_b) // [R13]
    else $error("compare B flag not cleared by write one");

  property p_w1c_wrap;
    wr_flags && wdat[0] && !wrap_evt |=> !flags.wrap;
  endproperty
  a_w1c_wrap : assert property (p_w1c_wrap) // [R15]
    else $error("wrap flag not cleared by write one");

  property p_ack_clears_a;
    irq_ack_i[tmr8_pkg::SRC_MATCH_A] && !set_a |=> !flags.match_a;
  endproperty
  a_ack_clears_a : assert property (p_ack_clears_a) // [R21]
    else $error("acknowledge did not clear compare A flag");

  property p_ack_clears_b;
    irq_ack_i[tmr8_pkg::SRC_MATCH_B] && !set_b |=> !flags.match_b;
  endproperty
  a_ack_clears_b : assert property (p_ack_clears_b) // [R21]
    else $error("acknowledge did not clear compare B flag");

  property p_irq_gate;
    irq_o[tmr8_pkg::SRC_MATCH_B] |-> gie_i && mask.match_b && flags.match_b;
  endproperty
  a_irq_gate : assert property (p_irq_gate) // [R12]
    else $error("compare B request without all enables");

  property p_wb_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_ack_one : assert property (p_wb_ack_one)
    else $error("ack held for more than one cycle");

  c_ctc_clear  : cover property (timer_tick && ctrl.clear_on_match_sel && match_a);
  c_free_wrap  : cover property (wrap_evt && !ctrl.clear_on_match_sel);
  c_blocked    : cover property (block && timer_tick && match_a);
  c_ext_tick   : cover property (ctrl.clk_src_sel == tmr8_pkg::CS_EXT_RISE && timer_tick);
  c_set_vs_clr : cover property (set_a && clr_vec[tmr8_pkg::SRC_MATCH_A]);

endmodule
`default_nettype wire

// [testbench/test_tmr8_timer.sv]
// testbench: register-level tests of the 8-bit timer/counter over its wishbone port
`default_nettype none
module test_tmr8_timer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_FLAGS = {tmr8_pkg::IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_CTRL  = {tmr8_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] A_COUNT = {tmr8_pkg::IDX_COUNT, 2'b00};
  localparam logic [7:0] A_CMP_A = {tmr8_pkg::IDX_CMP_A, 2'b00};
  localparam logic [7:0] A_CMP_B = {tmr8_pkg::IDX_CMP_B, 2'b00};
  localparam logic [7:0] A_MASK  = {tmr8_pkg::IDX_MASK, 2'b00};
  localparam logic [7:0] A_NONE  = 8'hFC;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ext_count_pin_i;
  logic        gie_i;
  logic [2:0]  irq_ack_i;
  logic [2:0]  irq_o;
  logic [31:0] rd;
  logic [7:0]  first;
  int          err_total;
  int          n_checks;

  // one row per internal clock-select code (stop, undivided, /8 /64 /256 /1024): divide ratio and expected advance over four periods
  tmr8_pkg::tmr8_clk_src_e cs_tab [6] = '{tmr8_pkg::CS_STOP, tmr8_pkg::CS_DIV1,
    tmr8_pkg::CS_DIV8, tmr8_pkg::CS_DIV64, tmr8_pkg::CS_DIV256, tmr8_pkg::CS_DIV1024};
  int div_tab [6] = '{1, 1, 8, 64, 256, 1024};
  logic [7:0] inc_tab [6] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};

  tmr8_timer i_dut (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .ext_count_pin_i (ext_count_pin_i),
    .gie_i           (gie_i),
    .irq_ack_i       (irq_ack_i),
    .irq_o           (irq_o)
  );

  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      finish_test();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb_xfer(1'b1, adr, 4'h1, {24'h00_0000, dat});
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    wb_xfer(1'b0, adr, 4'h1, 32'h0000_0000);
    check(rd, {24'h00_0000, exp});
  endtask

  // the pin edge needs three cycles to become a tick; six leaves margin
  task automatic pin_set(input logic v);
    @(posedge clk_i);
    ext_count_pin_i <= v;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic pulse();
    pin_set(1'b1);
    pin_set(1'b0);
  endtask

  task automatic ack_src(input logic [2:0] v);
    @(posedge clk_i);
    irq_ack_i <= v;
    @(posedge clk_i);
    irq_ack_i <= 3'h0;
  endtask

  task automatic irq_chk(input logic g, input logic [2:0] exp);
    @(posedge clk_i);
    gie_i <= g;
    @(negedge clk_i);
    check({29'h0000_0000, irq_o}, {29'h0000_0000, exp});
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    ext_count_pin_i = 1'b0;
    gie_i = 1'b0;
    irq_ack_i = 3'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(A_FLAGS, 8'h00);
    rd_chk(A_CTRL, 8'h00);
    rd_chk(A_COUNT, 8'h00);
    rd_chk(A_CMP_A, 8'h00);
    rd_chk(A_CMP_B, 8'h00);
    rd_chk(A_MASK, 8'h00);
    rd_chk(A_NONE, 8'h00);
    wr(A_CTRL, 8'hFF);
    rd_chk(A_CTRL, 8'h0F);
    wr(A_MASK, 8'hFF);
    rd_chk(A_MASK, 8'h07);
    wr(A_MASK, 8'h00);
    wr(A_CTRL, 8'h00);
    wr(A_COUNT, 8'h10);
    wb_xfer(1'b1, A_COUNT, 4'h0, 32'h0000_0055);
    rd_chk(A_COUNT, 8'h10);
    // two reads 4*N cycles apart must differ by the row's advance: four ticks, or none when stopped
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, {5'h00, cs_tab[i]});
      wb_xfer(1'b0, A_COUNT, 4'h1, 32'h0000_0000);
      first = rd[7:0];
      repeat (4 * div_tab[i] - 3) @(posedge clk_i);
      wb_xfer(1'b0, A_COUNT, 4'h1, 32'h0000_0000);
      check(rd, {24'h00_0000, first + inc_tab[i]});
    end
    // in undivided mode every write lands on a tick
    wr(A_CTRL, 8'h01);
    wr(A_COUNT, 8'h80);
    rd_chk(A_COUNT, 8'h81);
    wr(A_CTRL, 8'h06);
    wr(A_COUNT, 8'h20);
    pin_set(1'b1);
    rd_chk(A_COUNT, 8'h20);
    pin_set(1'b0);
    rd_chk(A_COUNT, 8'h21);
    wr(A_CTRL, 8'h07);
    pin_set(1'b1);
    rd_chk(A_COUNT, 8'h22);
    pin_set(1'b0);
    rd_chk(A_COUNT, 8'h22);
    wr(A_CMP_A, 8'h31);
    wr(A_CMP_B, 8'h32);
    wr(A_COUNT, 8'h30);
    wr(A_FLAGS, 8'h07);
    rd_chk(A_FLAGS, 8'h00);
    pulse();
    rd_chk(A_FLAGS, 8'h00);
    pulse();
    rd_chk(A_FLAGS, 8'h02);
    pulse();
    rd_chk(A_COUNT, 8'h33);
    rd_chk(A_FLAGS, 8'h06);
    wr(A_MASK, 8'h07);
    irq_chk(1'b1, 3'h6);
    irq_chk(1'b0, 3'h0);
    wr(A_FLAGS, 8'h02);
    rd_chk(A_FLAGS, 8'h04);
    ack_src(3'h4);
    rd_chk(A_FLAGS, 8'h00);
    // count written equal to compare A: that tick's match is dropped
    wr(A_COUNT, 8'h31); // pin is still, so the counter is not running here
    pulse();
    rd_chk(A_COUNT, 8'h32);
    rd_chk(A_FLAGS, 8'h00);
    pulse();
    rd_chk(A_FLAGS, 8'h04);
    wr(A_FLAGS, 8'h07);
    wr(A_COUNT, 8'hFF);
    pulse();
    rd_chk(A_COUNT, 8'h00);
    rd_chk(A_FLAGS, 8'h01);
    irq_chk(1'b1, 3'h1);
    ack_src(3'h1);
    rd_chk(A_FLAGS, 8'h00);
    irq_chk(1'b0, 3'h0);
    wr(A_CMP_A, 8'h05);
    wr(A_CTRL, 8'h0F);
    wr(A_COUNT, 8'h04);
    pulse();
    pulse();
    rd_chk(A_COUNT, 8'h00);
    rd_chk(A_FLAGS, 8'h02);
    wr(A_CMP_A, 8'h01);
    pulse();
    rd_chk(A_COUNT, 8'h01);
    pulse();
    rd_chk(A_COUNT, 8'h00);
    irq_chk(1'b1, 3'h2);
    ack_src(3'h2);
    rd_chk(A_FLAGS, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
